//--- rtl/sram_tap.sv
// Functional notes
// - sample on test clock rise, drive on fall
// - mode select steers state machine; pulled high
// - serial data enters msb of selected register
// - output shows lsb, changes on falling edge
// - output driven only in shift states
// - five high mode selects force reset state
// - port reset leaves memory operation undisturbed
// - power up resets port, output floats
// - one register in path, chosen by instruction
// - three-bit instruction register, shifted serially
// - identification instruction after reset
// - capture-IR loads 01 into low bits
// - one-bit bypass, cleared at capture-DR when selected
// - capture-DR loads pin ring, shift-DR shifts
// - three boundary instructions capture pin ring
// - boundary chain includes unconnected position cells
// - identification capture loads hardwired 32-bit value
// - new instruction acts at update-IR only
// - bit 108 enables data outputs under extest
`timescale 1ns/1ps
`default_nettype none
module sram_tap (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic i_tdi,
	input wire logic [sram_tap_pkg::BSR_LEN-1:0] i_pin_ring,
	output logic o_tdo,
	output logic o_tdo_oe_n,
	output logic o_q_out_en,
	output logic o_extest,
	output logic [sram_tap_pkg::BSR_LEN-1:0] o_bsr_hold
);
	import sram_tap_pkg::*;

	// ==========================================
	// pin synchronisers; mode and data take two stages, the test clock a third
	// for edge detection, so the sampled mode and data stay aligned with the clock edge
	logic tck_s1_r, tck_s2_r, tck_s3_r;
	logic tms_s1_r, tms_s2_r;
	logic tdi_s1_r, tdi_s2_r;
	always_ff @(posedge i_sys_clk) begin
		tck_s1_r <= i_tck;
		tck_s2_r <= tck_s1_r;
		tck_s3_r <= tck_s2_r;
		tms_s1_r <= i_tms;
		tms_s2_r <= tms_s1_r;
		tdi_s1_r <= i_tdi;
		tdi_s2_r <= tdi_s1_r;
	end
	wire tck_rise = tck_s2_r & ~tck_s3_r;
	wire tck_fall = ~tck_s2_r & tck_s3_r;

	// ==========================================
	// state machine
	tap_state_e state_r, state_nxt;
	always_comb begin
		case (state_r)
			ST_TLR: state_nxt = tms_s2_r ? ST_TLR : ST_RTI;
			ST_RTI: state_nxt = tms_s2_r ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: state_nxt = tms_s2_r ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: state_nxt = tms_s2_r ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: state_nxt = tms_s2_r ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: state_nxt = tms_s2_r ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: state_nxt = tms_s2_r ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: state_nxt = tms_s2_r ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: state_nxt = tms_s2_r ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: state_nxt = tms_s2_r ? ST_TLR : ST_CAP_IR;
			ST_CAP_IR: state_nxt = tms_s2_r ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: state_nxt = tms_s2_r ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: state_nxt = tms_s2_r ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: state_nxt = tms_s2_r ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: state_nxt = tms_s2_r ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: state_nxt = tms_s2_r ? ST_SEL_DR : ST_RTI;
			default: state_nxt = ST_TLR;
		endcase
	end

	// ==========================================
	// decode
	logic [IR_W-1:0] ir_r, ir_sh_r;
	logic bypass_r;
	logic [BSR_LEN-1:0] bsr_sh_r, bsr_hold_r;
	logic [ID_W-1:0] id_sh_r;

	wire go_tlr = tck_rise & (state_nxt == ST_TLR);
	wire in_shift = (state_r == ST_SH_DR) | (state_r == ST_SH_IR);
	wire sel_id = (ir_r == INS_IDCODE);
	wire sel_bsr = (ir_r == INS_EXTEST) | (ir_r == INS_SAMPLE_Z) | (ir_r == INS_SAMPLE_PRE);
	// reserved codes fall back to bypass so the chain stays intact
	wire sel_byp = ~sel_id & ~sel_bsr;
	wire is_ext = (ir_r == INS_EXTEST);
	wire dr_lsb = sel_id ? id_sh_r[0] : (sel_bsr ? bsr_sh_r[0] : bypass_r);
	wire tdo_nxt = (state_r == ST_SH_IR) ? ir_sh_r[0] : dr_lsb;
	wire cap_dr = tck_rise & (state_r == ST_CAP_DR);
	wire sh_dr = tck_rise & (state_r == ST_SH_DR);
	wire upd_dr = tck_rise & (state_r == ST_UPD_DR);
	// sample z floats the data outputs; extest takes bit 108; others leave memory alone
	wire q_en_nxt = is_ext ? bsr_hold_r[BSR_OE_BIT] : (ir_r != INS_SAMPLE_Z);

	// ==========================================
	// state and instruction; i_rst stands in for power up
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			state_r <= ST_TLR;
			ir_r <= INS_IDCODE;
		end else if (tck_rise) begin
			state_r <= state_nxt;
			if (state_nxt == ST_TLR)
				ir_r <= INS_IDCODE;
			else if (state_r == ST_UPD_IR)
				ir_r <= ir_sh_r;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			ir_sh_r <= INS_IDCODE;
		else if (tck_rise && state_r == ST_CAP_IR)
			ir_sh_r <= {1'h0, IR_CAP_LOW};
		else if (tck_rise && state_r == ST_SH_IR)
			ir_sh_r <= {tdi_s2_r, ir_sh_r[IR_W-1:1]};
	end

	// ==========================================
	// data registers
	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			bypass_r <= 1'h0;
		else if (cap_dr && sel_byp)
			bypass_r <= 1'h0;
		else if (sh_dr && sel_byp)
			bypass_r <= tdi_s2_r;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			id_sh_r <= ID_VALUE;
		else if (cap_dr && sel_id)
			id_sh_r <= ID_VALUE;
		else if (sh_dr && sel_id)
			id_sh_r <= {tdi_s2_r, id_sh_r[ID_W-1:1]};
	end

	// chain covers the real pins and the unconnected positions alike
	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			bsr_sh_r <= '0;
		else if (cap_dr && sel_bsr)
			bsr_sh_r <= i_pin_ring;
		else if (sh_dr && sel_bsr)
			bsr_sh_r <= {tdi_s2_r, bsr_sh_r[BSR_LEN-1:1]};
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst || go_tlr)
			bsr_hold_r <= BSR_HOLD_RST;
		else if (upd_dr && (is_ext || ir_r == INS_SAMPLE_PRE))
			bsr_hold_r <= bsr_sh_r;
	end

	// ==========================================
	// outputs; the pin ring is sampled, so a sram clock that
	// is moving during capture may read back either level
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_tdo <= 1'h0;
			o_tdo_oe_n <= 1'h1;
		end else if (tck_fall) begin
			o_tdo <= tdo_nxt;
			o_tdo_oe_n <= ~in_shift;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_q_out_en <= 1'h1;
			o_extest <= 1'h0;
		end else begin
			o_q_out_en <= q_en_nxt;
			o_extest <= is_ext;
		end
	end
	assign o_bsr_hold = bsr_hold_r;

	// ==========================================
	// checks
	logic [2:0] tms_cnt_r;
	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			tms_cnt_r <= 3'h0;
		else if (tck_rise)
			tms_cnt_r <= !tms_s2_r ? 3'h0 : (tms_cnt_r == TMS_RST_CNT ? tms_cnt_r : tms_cnt_r + 3'h1);
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	sequence s_cap_dr;
		tck_rise && state_r == ST_CAP_DR;
	endsequence
	sequence s_sh_dr;
		tck_rise && state_r == ST_SH_DR;
	endsequence

	AST_TDO_FALL: assert property ($changed(o_tdo) |-> $past(tck_fall))
		else $error("tdo moved off a falling edge");
	AST_OE_SHIFT: assert property (tck_fall && in_shift |=> !o_tdo_oe_n)
		else $error("tdo not driven in shift state");
	AST_OE_IDLE: assert property (tck_fall && !in_shift |=> o_tdo_oe_n)
		else $error("tdo driven outside shift");
	AST_FIVE_TMS: assert property (tms_cnt_r == TMS_RST_CNT |-> state_r == ST_TLR)
		else $error("five tms highs did not reset");
	AST_IR_RST: assert property (state_r == ST_TLR |-> ir_r == INS_IDCODE)
		else $error("reset state lacks id instruction");
	AST_CAP_IR: assert property (tck_rise && state_r == ST_CAP_IR |=> ir_sh_r[1:0] == IR_CAP_LOW)
		else $error("capture-ir pattern wrong");
	wire ir_load_ok = tck_rise & ((state_r == ST_UPD_IR) | (state_nxt == ST_TLR));
	AST_IR_UPD: assert property ($changed(ir_r) |-> $past(ir_load_ok))
		else $error("instruction changed outside update");
	AST_BYP_CLR: assert property (s_cap_dr and sel_byp |=> !bypass_r)
		else $error("bypass not cleared at capture");
	AST_BYP_SH: assert property (s_sh_dr and sel_byp |=> bypass_r == $past(tdi_s2_r))
		else $error("bypass did not take tdi");
	AST_ID_CAP: assert property (s_cap_dr and sel_id |=> id_sh_r == ID_VALUE)
		else $error("id value not captured");
	AST_BSR_CAP: assert property (s_cap_dr and sel_bsr |=> bsr_sh_r == $past(i_pin_ring))
		else $error("pin ring not captured");
	AST_Q_EXT: assert property (is_ext ##1 is_ext |-> o_q_out_en == $past(bsr_hold_r[BSR_OE_BIT]))
		else $error("output enable not from bit 108");

	// ==========================================
	// checks: instruction path
	sequence s_cap_ir;
		tck_rise && state_r == ST_CAP_IR;
	endsequence
	sequence s_sh_ir;
		tck_rise && state_r == ST_SH_IR;
	endsequence
	sequence s_upd_ir;
		tck_rise && state_r == ST_UPD_IR;
	endsequence
	sequence s_enter_tlr;
		tck_rise && state_nxt == ST_TLR;
	endsequence

	AST_IR_SHIFT: assert property (s_sh_ir |=> ir_sh_r[IR_W-1] == $past(tdi_s2_r))
		else $error("instruction shift lost tdi");
	AST_IR_CAP_TOP: assert property (s_cap_ir |=> ir_sh_r[IR_W-1] == 1'h0)
		else $error("capture-ir top bit not clear");
	AST_IR_LOAD: assert property (s_upd_ir |=> ir_r == $past(ir_sh_r))
		else $error("update-ir did not load instruction");
	AST_TLR_IR: assert property (s_enter_tlr |=> state_r == ST_TLR && ir_r == INS_IDCODE)
		else $error("reset entry lost id instruction");
	AST_ST_ONEHOT: assert property ($onehot(state_r))
		else $error("port state not one-hot");
	AST_ONE_REG: assert property ($onehot({sel_id, sel_bsr, sel_byp}))
		else $error("not exactly one data register selected");

	// ==========================================
	// checks: data path
	sequence s_upd_dr;
		tck_rise && state_r == ST_UPD_DR;
	endsequence
	sequence s_fall_sh_ir;
		tck_fall && state_r == ST_SH_IR;
	endsequence
	sequence s_fall_sh_dr;
		tck_fall && state_r == ST_SH_DR;
	endsequence
	// sample z never loads the preload latches at update-dr, so the outputs stay put
	wire hold_ins = is_ext | (ir_r == INS_SAMPLE_PRE);

	AST_ID_SHIFT: assert property (s_sh_dr and sel_id |=> id_sh_r[ID_W-1] == $past(tdi_s2_r))
		else $error("id shift lost tdi");
	AST_BSR_SHIFT: assert property (s_sh_dr and sel_bsr |=> bsr_sh_r[BSR_LEN-1] == $past(tdi_s2_r))
		else $error("boundary shift lost tdi");
	AST_HOLD_UPD: assert property (s_upd_dr and hold_ins |=> bsr_hold_r == $past(bsr_sh_r))
		else $error("preload latches not updated");
	AST_TLR_HOLD: assert property (state_r == ST_TLR |-> bsr_hold_r == BSR_HOLD_RST)
		else $error("preload latches not preset in reset state");

	// ==========================================
	// checks: outputs
	AST_TDO_IR: assert property (s_fall_sh_ir |=> o_tdo == $past(ir_sh_r[0]))
		else $error("tdo not instruction lsb");
	AST_TDO_ID: assert property (s_fall_sh_dr and sel_id |=> o_tdo == $past(id_sh_r[0]))
		else $error("tdo not id lsb");
	AST_TDO_BSR: assert property (s_fall_sh_dr and sel_bsr |=> o_tdo == $past(bsr_sh_r[0]))
		else $error("tdo not boundary lsb");
	AST_TDO_BYP: assert property (s_fall_sh_dr and sel_byp |=> o_tdo == $past(bypass_r))
		else $error("tdo not bypass bit");
	AST_OE_FALL: assert property ($changed(o_tdo_oe_n) |-> $past(tck_fall))
		else $error("tdo enable moved off a falling edge");
	AST_Q_RST: assert property (state_r == ST_TLR |=> o_q_out_en)
		else $error("reset state disturbed memory outputs");
	AST_EXT_ON: assert property (is_ext |=> o_extest)
		else $error("extest flag missing");
	AST_EXT_OFF: assert property (!is_ext |=> !o_extest)
		else $error("extest flag stuck");
endmodule : sram_tap
`default_nettype wire

//--- shared/sram_tap_pkg.sv
package sram_tap_pkg;
	// ==========================================
	// sizes
	localparam int IR_W = 3;
	localparam int ID_W = 32;
	localparam int BSR_LEN = 109;
	localparam int BSR_W = 7;
	localparam logic [BSR_W-1:0] BSR_OE_BIT = 7'h6C;
	localparam logic [BSR_LEN-1:0] BSR_HOLD_RST = {1'h1, 108'h0};
	// value is arbitrary; lsb of an id code is always one
	localparam logic [ID_W-1:0] ID_VALUE = 32'h0A5C_3001;
	localparam logic [1:0] IR_CAP_LOW = 2'h1;
	localparam logic [2:0] TMS_RST_CNT = 3'h5;

	// ==========================================
	// instruction codes
	localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
	localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
	localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
	localparam logic [IR_W-1:0] INS_SAMPLE_PRE = 3'h4;
	localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;

	// ==========================================
	// port states
	typedef enum logic [15:0] {
		ST_TLR = 16'h0001,
		ST_RTI = 16'h0002,
		ST_SEL_DR = 16'h0004,
		ST_CAP_DR = 16'h0008,
		ST_SH_DR = 16'h0010,
		ST_EX1_DR = 16'h0020,
		ST_PAU_DR = 16'h0040,
		ST_EX2_DR = 16'h0080,
		ST_UPD_DR = 16'h0100,
		ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400,
		ST_SH_IR = 16'h0800,
		ST_EX1_IR = 16'h1000,
		ST_PAU_IR = 16'h2000,
		ST_EX2_IR = 16'h4000,
		ST_UPD_IR = 16'h8000
	} tap_state_e;
endpackage : sram_tap_pkg

//--- verif/jtag_host.sv
`timescale 1ns/1ps
`default_nettype none
module jtag_host (
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi,
	input wire logic i_tdo,
	input wire logic i_tdo_oe_n
);
	logic smp_v = 1'b0;
	event got;
	// ====
	// idle: test clock parked low, pulled-up lines read high
	initial begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b1;
	end
	// one test clock; inputs move at the fall so setup and hold are both half a period
	task automatic step(input logic tms_v, input logic tdi_v);
		o_tms = tms_v;
		o_tdi = tdi_v;
		#62.0;
		// an undriven line keeps no value: invert the last one seen
		smp_v = i_tdo_oe_n ? ~smp_v : i_tdo;
		if (i_tdo_oe_n === 1'b0) ->got;
		#0.5 o_tck = 1'b1;
		#62.5 o_tck = 1'b0;
	endtask : step
endmodule : jtag_host
`default_nettype wire

//--- verif/test_sram_tap.sv
`timescale 1ns/1ps
`default_nettype none
module test_sram_tap;
	import sram_tap_pkg::*;
	logic i_sys_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [BSR_LEN-1:0] ring = '0;
	logic tck, tms, tdi, tdo, tdo_oe_n, q_out_en, extest;
	logic [BSR_LEN-1:0] hold;
	logic [31:0] seed = 32'hC268B6A0;
	logic [2:0] cd [3] = '{INS_SAMPLE_PRE, INS_EXTEST, INS_SAMPLE_Z};
	logic exp_q[$];
	int fail_count = 0;
	int cmp_count = 0;
	always #5 i_sys_clk = ~i_sys_clk;
	sram_tap u_sram_tap (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
		.i_pin_ring(ring), .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n), .o_q_out_en(q_out_en), .o_extest(extest),
		.o_bsr_hold(hold));
	jtag_host u_jtag_host (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo), .i_tdo_oe_n(tdo_oe_n));
	// ====
	// shared helpers
	task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : final_report
	function automatic logic [127:0] rnd();
		logic [127:0] v;
		for (int i = 0; i < 128; i++) begin
			seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
			v[i] = seed[0];
		end
		return v;
	endfunction : rnd
	// from idle: capture, shift n bits lsb first, update, back to idle
	task automatic shift(input bit ir, input int n, input logic [127:0] din, input logic [127:0] dexp);
		u_jtag_host.step(1'b1, 1'b0);
		if (ir) u_jtag_host.step(1'b1, 1'b0);
		u_jtag_host.step(1'b0, 1'b0);
		u_jtag_host.step(1'b0, 1'b0);
		for (int i = 0; i < n; i++) begin
			exp_q.push_back(dexp[i]);
			u_jtag_host.step(i == n - 1, din[i]);
		end
		u_jtag_host.step(1'b1, 1'b0);
		u_jtag_host.step(1'b0, 1'b0);
	endtask : shift
	// ====
	// every driven tdo bit must match the oldest note
	always @(u_jtag_host.got) begin
		chk("tdo driven", exp_q.size() != 0, 1'b1);
		if (exp_q.size() != 0) chk("tdo", u_jtag_host.smp_v, exp_q.pop_front());
	end
	// ====
	// main sequence
	initial begin
		logic [127:0] v;
		logic [127:0] r;
		repeat (16) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		repeat (4) @(posedge i_sys_clk);
		#3;
		chk("oe_n reset", tdo_oe_n, 1'b1);
		chk("q_out_en reset", q_out_en, 1'b1);
		chk("hold reset", hold, BSR_HOLD_RST);
		u_jtag_host.step(1'b0, 1'b0);
		v = rnd();
		shift(0, 32, v, ID_VALUE);
		shift(0, 32, ~v, ID_VALUE);
		$display("test identification done");
		shift(1, 3, INS_BYPASS, IR_CAP_LOW);
		v = rnd();
		v[39] = 1'b1;
		shift(0, 40, v, {v[126:0], 1'b0});
		shift(0, 8, ~v, {~v[126:0], 1'b0});
		$display("test bypass done");
		for (int k = 0; k < 3; k++) begin
			shift(1, 3, cd[k], IR_CAP_LOW);
			chk("extest", extest, cd[k] == INS_EXTEST);
			chk("q_out_en", q_out_en, cd[k] == INS_SAMPLE_PRE);
			r = rnd();
			v = rnd();
			v[108] = (cd[k] == INS_EXTEST);
			@(posedge i_sys_clk) ring <= r[108:0];
			shift(0, BSR_LEN, v, r);
			if (cd[k] != INS_SAMPLE_Z) chk("hold", hold, v[108:0]);
			chk("q_out_en shifted", q_out_en, cd[k] != INS_SAMPLE_Z);
		end
		$display("test boundary done");
		r = rnd();
		@(posedge i_sys_clk) ring <= r[108:0];
		u_jtag_host.step(1'b1, 1'b0);
		u_jtag_host.step(1'b0, 1'b0);
		u_jtag_host.step(1'b0, 1'b0);
		exp_q.push_back(r[0]);
		repeat (5) u_jtag_host.step(1'b1, 1'b0);
		chk("hold tlr", hold, BSR_HOLD_RST);
		chk("q_out_en tlr", q_out_en, 1'b1);
		u_jtag_host.step(1'b0, 1'b0);
		shift(0, 32, v, ID_VALUE);
		$display("test mode reset done");
		final_report();
	end
	// about 560 test clocks expected; give over four times that
	initial begin
		repeat (30000) @(posedge i_sys_clk);
		fail_count++;
		final_report();
	end
endmodule : test_sram_tap
`default_nettype wire
